// >>> src/core_flags_map.svh
// Named constants of the flag register and data address former.
`ifndef CORE_FLAGS_MAP_SVH
`define CORE_FLAGS_MAP_SVH
`define FLAG_NEG 3'h4
`define FLAG_OVF 3'h3
`define FLAG_ZERO 3'h2
`define FLAG_DIGIT 3'h1
`define FLAG_CARRY 3'h0
`define FLAG_ZERO_MASK 5'h04
`define ADDR_FLAGS 12'hFA0
`define ADDR_BANK 12'hFA1
`define VIRT_TOP 7'h7C
`define VIRT_KINDS 3'h5
`define NUM_PTRS 2'h3
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH 4'hF
`define OFFSET_MAX 8'h5F
`define OFFSET_PTR 2
`define RIDX_FLAGS 4'h0
`define RIDX_BANK 4'h1
`define RIDX_PTR0 4'h2
`define SIGN_BIT 7
`endif

// >>> src/core_flags_pkg.sv
// Types shared by the flag register and data address former.
package core_flags_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_WORKING_FILE_OP = 4'h1,
        OP_ADD_LITERAL_OP = 4'h2,
        OP_SUB_WORKING_FILE_OP = 4'h3,
        OP_SUB_LITERAL_OP = 4'h4,
        OP_ANDWF = 4'h5,
        OP_RRF = 4'h6,
        OP_RLF = 4'h7,
        OP_CLEAR_FILE_OP = 4'h8,
        OP_BCF = 4'h9,
        OP_BSF = 4'hA,
        OP_NIBBLE_SWAP_OP = 4'hB,
        OP_WORKING_TO_FILE_MOVE_OP = 4'hC,
        OP_FILE_TO_FILE_MOVE_OP = 4'hD,
        OP_JUMP = 4'hE
    } op_t;
    typedef enum logic [2:0] {
        IND_PLAIN = 3'h0,
        IND_POST_INCREMENT_OPERAND = 3'h1,
        IND_POST_DECREMENT_OPERAND = 3'h2,
        IND_PRE_INCREMENT_OPERAND = 3'h3,
        IND_POINTER_PLUS_WORKING_OPERAND = 3'h4
    } ind_kind_t;
    typedef struct packed {
        logic [4:0] flags;
        logic [3:0] bank;
        logic [2:0][11:0] ptr;
        logic [11:0] dataAddr;
        logic [7:0] resultData;
        logic fileWrite;
        logic workWrite;
        logic [19:0] progTarget;
        logic progJump;
        logic [7:0] regRdata;
        logic execDone;
    } state_t;
endpackage

// >>> src/core_flags_addr.sv
// Condition flag register, data address former and pointer pairs of the core.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "core_flags_map.svh"
// Notes on behaviour
// - Flag-altering op blocks flag destination write.
// - Clear-file on flags sets only zero.
// - Negative flag follows result sign bit.
// - Overflow flag marks signed sign-bit change.
// - Zero flag set on zero result.
// - Digit carry from low-nibble carry out.
// - Carry from most significant carry out.
// - Subtract adds complement; carry means no borrow.
// - Rotates load digit carry and carry.
// - Jump carries 20-bit program address.
// - Low opcode byte gives direct address.
// - Access bit one joins bank select.
// - Access bit zero selects access bank.
// - Full-address move ignores bank select.
// - Destination bit picks file or working.
// - Three 12-bit pointer pairs.
// - Indirect operand accesses pointed location.
// - Indirect uses full pointer, no banking.
// - Literal-offset mode only when extended enabled.
// - Pointer inc, dec, pre_increment_operand and plus-working.
// - Pointer carries across pair, flags untouched.
// - Pointer at virtual operand reads zero.
// - Small access offset adds to third pointer.
module core_flags_addr (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic execValid,
    input wire core_flags_pkg::op_t opSel,
    input wire logic [7:0] fileAddr,
    input wire logic accessBit,
    input wire logic destBit,
    input wire logic [2:0] bitSel,
    input wire logic [11:0] longAddr,
    input wire logic [19:0] progLit,
    input wire logic [7:0] workIn,
    input wire logic [7:0] fileData,
    input wire logic extIsaEnable,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic [11:0] dataAddr,
    output logic [7:0] resultData,
    output logic fileWrite,
    output logic workWrite,
    output logic [19:0] progTarget,
    output logic progJump,
    output logic [7:0] flagsOut,
    output logic execDone
);
    import core_flags_pkg::*;

    state_t state_reg;
    state_t state_next;

    // Virtual operands sit in one block; slots past the third pointer are plain registers.
    function automatic logic isVirtual(input logic [11:0] a);
        isVirtual = (a[11:5] == `VIRT_TOP) && (a[4:3] < `NUM_PTRS) && (a[2:0] < `VIRT_KINDS);
    endfunction

    function automatic logic [7:0] readReg(input logic [3:0] idx, input state_t s);
        readReg = 8'h00;
        if (idx == `RIDX_FLAGS) begin
            readReg = {3'h0, s.flags};
        end else if (idx == `RIDX_BANK) begin
            readReg = {4'h0, s.bank};
        end
        for (int n = 0; n < 3; n++) begin
            if (idx == 4'(`RIDX_PTR0 + 2 * n)) begin
                readReg = s.ptr[n][7:0];
            end else if (idx == 4'(`RIDX_PTR0 + 2 * n + 1)) begin
                readReg = {4'h0, s.ptr[n][11:8]};
            end
        end
    endfunction

    logic useLong;
    logic offsetMode;
    logic [11:0] directAddr;
    logic isInd;
    logic [1:0] ptrIdx;
    ind_kind_t kind;
    logic [11:0] ptrSel;
    logic [11:0] ptrUse;
    logic [11:0] ptrAfter;
    logic [11:0] effAddr;
    logic nullAcc;
    logic [7:0] srcData;
    logic isSub;
    logic [7:0] aOp;
    logic [7:0] bOp;
    logic [8:0] sum9;
    logic [4:0] half5;

    assign useLong = (opSel == OP_FILE_TO_FILE_MOVE_OP);
    assign offsetMode = extIsaEnable && !accessBit && (fileAddr <= `OFFSET_MAX);
    always_comb begin
        if (useLong) begin
            directAddr = longAddr;
        end else if (offsetMode) begin
            directAddr = state_reg.ptr[`OFFSET_PTR] + {4'h0, fileAddr};
        end else if (accessBit) begin
            directAddr = {state_reg.bank, fileAddr};
        end else if (fileAddr >= `ACCESS_SPLIT) begin
            directAddr = {`ACCESS_HIGH, fileAddr};
        end else begin
            directAddr = {4'h0, fileAddr};
        end
    end

    assign isInd = isVirtual(directAddr);
    assign ptrIdx = directAddr[4:3];
    assign kind = ind_kind_t'(directAddr[2:0]);
    assign ptrSel = (ptrIdx == 2'h2) ? state_reg.ptr[2] : (ptrIdx[0] ? state_reg.ptr[1] : state_reg.ptr[0]);
    always_comb begin
        case (kind)
            IND_PRE_INCREMENT_OPERAND: ptrUse = ptrSel + 12'h001;
            IND_POINTER_PLUS_WORKING_OPERAND: ptrUse = ptrSel + {{4{workIn[`SIGN_BIT]}}, workIn};
            default: ptrUse = ptrSel;
        endcase
        case (kind)
            IND_POST_INCREMENT_OPERAND: ptrAfter = ptrSel + 12'h001;
            IND_POST_DECREMENT_OPERAND: ptrAfter = ptrSel - 12'h001;
            IND_PRE_INCREMENT_OPERAND: ptrAfter = ptrSel + 12'h001;
            default: ptrAfter = ptrSel;
        endcase
    end
    assign effAddr = isInd ? ptrUse : directAddr;
    assign nullAcc = isInd && isVirtual(ptrUse);

    // The flag and bank registers live here, so reads of them are served locally.
    always_comb begin
        if (nullAcc) begin
            srcData = 8'h00;
        end else if (effAddr == `ADDR_FLAGS) begin
            srcData = {3'h0, state_reg.flags};
        end else if (effAddr == `ADDR_BANK) begin
            srcData = {4'h0, state_reg.bank};
        end else begin
            srcData = fileData;
        end
    end

    assign isSub = (opSel == OP_SUB_WORKING_FILE_OP) || (opSel == OP_SUB_LITERAL_OP);
    assign aOp = (opSel == OP_ADD_WORKING_FILE_OP || opSel == OP_SUB_WORKING_FILE_OP) ? srcData : ((opSel == OP_SUB_LITERAL_OP) ? fileAddr : workIn);
    assign bOp = (opSel == OP_ADD_LITERAL_OP) ? fileAddr : ((opSel == OP_ADD_WORKING_FILE_OP) ? workIn : ~workIn);
    assign sum9 = {1'b0, aOp} + {1'b0, bOp} + {8'h00, isSub};
    assign half5 = {1'b0, aOp[3:0]} + {1'b0, bOp[3:0]} + {4'h0, isSub};

    always_comb begin
        logic [7:0] res;
        logic [4:0] fl;
        logic alters;
        logic toFile;
        logic toWork;
        res = srcData;
        fl = state_reg.flags;
        alters = 1'b0;
        toFile = 1'b0;
        toWork = 1'b0;
        state_next = state_reg;
        state_next.fileWrite = 1'b0;
        state_next.workWrite = 1'b0;
        state_next.progJump = 1'b0;
        state_next.execDone = 1'b0;
        state_next.regRdata = regRd ? readReg(regAddr, state_reg) : 8'h00;
        if (regWr) begin
            if (regAddr == `RIDX_FLAGS) begin
                state_next.flags = regWdata[4:0];
            end else if (regAddr == `RIDX_BANK) begin
                state_next.bank = regWdata[3:0];
            end
            for (int n = 0; n < 3; n++) begin
                if (regAddr == 4'(`RIDX_PTR0 + 2 * n)) begin
                    state_next.ptr[n][7:0] = regWdata;
                end else if (regAddr == 4'(`RIDX_PTR0 + 2 * n + 1)) begin
                    state_next.ptr[n][11:8] = regWdata[3:0];
                end
            end
        end
        if (execValid) begin
            case (opSel)
                OP_ADD_WORKING_FILE_OP, OP_ADD_LITERAL_OP, OP_SUB_WORKING_FILE_OP, OP_SUB_LITERAL_OP: begin
                    res = sum9[7:0];
                    alters = 1'b1;
                    fl[`FLAG_DIGIT] = half5[4];
                    fl[`FLAG_CARRY] = sum9[8];
                    fl[`FLAG_OVF] = (aOp[7] == bOp[7]) && (sum9[7] != aOp[7]);
                    toFile = (opSel == OP_ADD_WORKING_FILE_OP || opSel == OP_SUB_WORKING_FILE_OP) && destBit;
                    toWork = !toFile;
                end
                OP_ANDWF: begin
                    res = srcData & workIn;
                    alters = 1'b1;
                    toFile = destBit;
                    toWork = !destBit;
                end
                OP_RRF: begin
                    res = {state_reg.flags[`FLAG_CARRY], srcData[7:1]};
                    alters = 1'b1;
                    fl[`FLAG_CARRY] = srcData[0];
                    fl[`FLAG_DIGIT] = srcData[4];
                    toFile = destBit;
                    toWork = !destBit;
                end
                OP_RLF: begin
                    res = {srcData[6:0], state_reg.flags[`FLAG_CARRY]};
                    alters = 1'b1;
                    fl[`FLAG_CARRY] = srcData[7];
                    fl[`FLAG_DIGIT] = srcData[3];
                    toFile = destBit;
                    toWork = !destBit;
                end
                OP_CLEAR_FILE_OP: begin
                    res = 8'h00;
                    alters = 1'b1;
                    toFile = 1'b1;
                end
                OP_BCF: begin
                    res[bitSel] = 1'b0;
                    toFile = 1'b1;
                end
                OP_BSF: begin
                    res[bitSel] = 1'b1;
                    toFile = 1'b1;
                end
                OP_NIBBLE_SWAP_OP: begin
                    res = {srcData[3:0], srcData[7:4]};
                    toFile = destBit;
                    toWork = !destBit;
                end
                OP_WORKING_TO_FILE_MOVE_OP: begin
                    res = workIn;
                    toFile = 1'b1;
                end
                OP_FILE_TO_FILE_MOVE_OP: begin
                    res = fileData;
                    toFile = 1'b1;
                end
                OP_JUMP: begin
                    state_next.progTarget = progLit;
                    state_next.progJump = 1'b1;
                end
                default: begin
                    res = srcData;
                end
            endcase
            if (alters) begin
                fl[`FLAG_NEG] = res[7];
                fl[`FLAG_ZERO] = (res == 8'h00);
                if (opSel == OP_CLEAR_FILE_OP) begin
                    fl = state_reg.flags | `FLAG_ZERO_MASK;
                end
                state_next.flags = fl;
            end
            state_next.dataAddr = effAddr;
            state_next.resultData = res;
            state_next.execDone = 1'b1;
            state_next.workWrite = toWork;
            if (toFile && !nullAcc) begin
                if (effAddr == `ADDR_FLAGS) begin
                    if (!alters) begin
                        state_next.flags = res[4:0];
                    end
                end else if (effAddr == `ADDR_BANK) begin
                    state_next.bank = res[3:0];
                end else begin
                    state_next.fileWrite = 1'b1;
                end
            end
            for (int n = 0; n < 3; n++) begin
                if (isInd && ptrIdx == 2'(n)) begin
                    state_next.ptr[n] = ptrAfter;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdata = state_reg.regRdata;
    assign dataAddr = state_reg.dataAddr;
    assign resultData = state_reg.resultData;
    assign fileWrite = state_reg.fileWrite;
    assign workWrite = state_reg.workWrite;
    assign progTarget = state_reg.progTarget;
    assign progJump = state_reg.progJump;
    assign flagsOut = {3'h0, state_reg.flags};
    assign execDone = state_reg.execDone;

    flag_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_ADD_WORKING_FILE_OP && destBit && effAddr == `ADDR_FLAGS && !regWr)
        |=> !fileWrite && (flagsOut[`FLAG_ZERO] == (resultData == 8'h00)))
        else $error("Flag destination write was not blocked.");
    clear_flags_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_CLEAR_FILE_OP && effAddr == `ADDR_FLAGS && !regWr)
        |=> flagsOut == ($past(flagsOut) | 8'h04))
        else $error("Clearing flags changed more than zero.");
    neg_sign_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && (opSel == OP_ADD_LITERAL_OP || opSel == OP_SUB_LITERAL_OP)) |=> flagsOut[`FLAG_NEG] == resultData[7])
        else $error("Negative flag does not follow sign.");
    add_carry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_ADD_LITERAL_OP)
        |=> flagsOut[`FLAG_CARRY] == (({1'b0, $past(workIn)} + {1'b0, $past(fileAddr)}) >= 9'h100))
        else $error("Add carry wrong.");
    sub_borrow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_SUB_LITERAL_OP) |=> flagsOut[`FLAG_CARRY] == ($past(fileAddr) >= $past(workIn)))
        else $error("Subtract borrow polarity wrong.");
    rotate_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_RRF)
        |=> flagsOut[`FLAG_CARRY] == $past(srcData[0]) && flagsOut[`FLAG_DIGIT] == $past(srcData[4]))
        else $error("Rotate flag load wrong.");
    bank_join_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && accessBit && !useLong && !isInd) |=> dataAddr == {$past(state_reg.bank), $past(fileAddr)})
        else $error("Banked address wrong.");
    access_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && !accessBit && !extIsaEnable && !useLong && fileAddr < `ACCESS_SPLIT)
        |=> dataAddr == {4'h0, $past(fileAddr)})
        else $error("Access bank address wrong.");
    post_inc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && isInd && ptrIdx == 2'h0 && kind == IND_POST_INCREMENT_OPERAND && !regWr)
        |=> state_reg.ptr[0] == $past(state_reg.ptr[0]) + 12'h001)
        else $error("Post-increment did not carry.");
    null_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && nullAcc) |=> !fileWrite && ($past(opSel) != OP_ANDWF || resultData == 8'h00))
        else $error("Virtual target was accessed.");
    ovf_sub_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && opSel == OP_SUB_LITERAL_OP)
        |=> flagsOut[`FLAG_OVF] == (($past(fileAddr[`SIGN_BIT]) != $past(workIn[`SIGN_BIT]))
            && (resultData[`SIGN_BIT] != $past(fileAddr[`SIGN_BIT]))))
        else $error("Subtract overflow flag wrong.");
    ptr_flags_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (execValid && isInd && opSel == OP_WORKING_TO_FILE_MOVE_OP && effAddr != `ADDR_FLAGS && !regWr) |=> $stable(flagsOut))
        else $error("Pointer update changed the flags.");
endmodule // core_flags_addr

// >>> verif/core_flags_addr_tb.sv
// Self-checking bench for the flag register and data address former.
`timescale 1ns/1ps
module core_flags_addr_tb;
    import core_flags_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic execValid = 1'b0;
    logic accessBit = 1'b0;
    logic destBit = 1'b0;
    logic extIsaEnable = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    op_t opSel = OP_NOP;
    logic [7:0] fileAddr = 8'h00;
    logic [7:0] workIn = 8'h00;
    logic [7:0] fileData = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [2:0] bitSel = 3'h0;
    logic [11:0] longAddr = 12'h000;
    logic [19:0] progLit = 20'h00000;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regRdata;
    logic [7:0] resultData;
    logic [7:0] flagsOut;
    logic [11:0] dataAddr;
    logic [19:0] progTarget;
    logic fileWrite;
    logic workWrite;
    logic progJump;
    logic execDone;
    logic [7:0] rd;
    int errorCnt = 0;
    int numChecks = 0;

    always #12.5 sys_clk = ~sys_clk;

    core_flags_addr uut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .execValid(execValid),
        .opSel(opSel),
        .fileAddr(fileAddr),
        .accessBit(accessBit),
        .destBit(destBit),
        .bitSel(bitSel),
        .longAddr(longAddr),
        .progLit(progLit),
        .workIn(workIn),
        .fileData(fileData),
        .extIsaEnable(extIsaEnable),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata),
        .dataAddr(dataAddr),
        .resultData(resultData),
        .fileWrite(fileWrite),
        .workWrite(workWrite),
        .progTarget(progTarget),
        .progJump(progJump),
        .flagsOut(flagsOut),
        .execDone(execDone)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic regw(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic regr(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdata;
    endtask

    // Outputs are sampled at the falling edge of the answer cycle, where they have settled.
    task automatic ex(input op_t op, input logic [7:0] f, input logic a, input logic d,
                      input logic [7:0] w, input logic [7:0] fd);
        @(posedge sys_clk);
        opSel <= op;
        fileAddr <= f;
        accessBit <= a;
        destBit <= d;
        workIn <= w;
        fileData <= fd;
        execValid <= 1'b1;
        @(posedge sys_clk);
        execValid <= 1'b0;
        @(negedge sys_clk);
        chk(execDone, 1);
    endtask

    // Returns negative, overflow, zero, digit carry, carry and the result byte.
    function automatic logic [12:0] alu(input logic [7:0] x, input logic [7:0] y, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        return {s[7], (x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    task automatic t_reset;
        chk(flagsOut, 0);
        regr(4'h0, rd);
        chk(rd, 0);
        regr(4'h3, rd);
        chk(rd, 0);
        regw(4'h8, 8'hAB);
        regr(4'h8, rd);
        chk(rd, 0);
        $display("reset and port test done");
    endtask

    task automatic t_arith;
        op_t ops[4] = '{OP_ADD_WORKING_FILE_OP, OP_ADD_LITERAL_OP, OP_SUB_WORKING_FILE_OP, OP_SUB_LITERAL_OP};
        logic [7:0] xs[4] = '{8'h01, 8'h7F, 8'h05, 8'h80};
        logic [7:0] ws[4] = '{8'hFF, 8'h01, 8'h06, 8'h01};
        logic [12:0] e;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                ex(ops[i], xs[k], 1'b0, 1'b0, ws[k], xs[k]);
                e = (i >= 2) ? alu(xs[k], ~ws[k], 1'b1) : alu(xs[k], ws[k], 1'b0);
                chk(resultData, e[7:0]);
                chk(flagsOut, {3'b000, e[12:8]});
                chk({workWrite, fileWrite}, 2'b10);
            end
        end
        ex(OP_ANDWF, 8'h20, 1'b0, 1'b1, 8'h0F, 8'hF0);
        chk(resultData, 8'h00);
        chk(flagsOut, 8'h0D);
        chk({workWrite, fileWrite}, 2'b01);
        $display("arithmetic test done");
    endtask

    task automatic t_rotate;
        regw(4'h0, 8'h01);
        ex(OP_RLF, 8'h20, 1'b0, 1'b1, 8'h00, 8'h88);
        chk(resultData, 8'h11);
        chk({flagsOut[4], flagsOut[2:0]}, 4'b0011);
        chk({workWrite, fileWrite}, 2'b01);
        ex(OP_RRF, 8'h20, 1'b0, 1'b1, 8'h00, 8'h10);
        chk(resultData, 8'h88);
        chk({flagsOut[4], flagsOut[2:0]}, 4'b1010);
        $display("rotate test done");
    endtask

    task automatic t_flagdest;
        regw(4'h0, 8'h1B);
        ex(OP_CLEAR_FILE_OP, 8'hA0, 1'b0, 1'b1, 8'h00, 8'h1B);
        chk(flagsOut, 8'h1F);
        chk(fileWrite, 0);
        ex(OP_ADD_WORKING_FILE_OP, 8'hA0, 1'b0, 1'b1, 8'h01, 8'h1F);
        chk(flagsOut, 8'h02);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'hA0, 1'b0, 1'b1, 8'hE5, 8'h02);
        chk(flagsOut, 8'h05);
        regr(4'h0, rd);
        chk(rd, 8'h05);
        @(posedge sys_clk);
        bitSel <= 3'h4;
        ex(OP_BSF, 8'hA0, 1'b0, 1'b1, 8'h00, 8'h05);
        chk(flagsOut, 8'h15);
        ex(OP_NIBBLE_SWAP_OP, 8'hA0, 1'b0, 1'b1, 8'h00, 8'h15);
        chk(flagsOut, 8'h11);
        @(negedge sys_clk);
        chk(regRdata, 0);
        $display("flag destination test done");
    endtask

    task automatic t_direct;
        regw(4'h1, 8'h05);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h34, 1'b1, 1'b1, 8'h9C, 8'h00);
        chk(dataAddr, 12'h534);
        chk({resultData, fileWrite}, 9'h139);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h34, 1'b0, 1'b1, 8'h9C, 8'h00);
        chk(dataAddr, 12'h034);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h70, 1'b0, 1'b1, 8'h9C, 8'h00);
        chk(dataAddr, 12'hF70);
        @(posedge sys_clk);
        longAddr <= 12'h7AB;
        ex(OP_FILE_TO_FILE_MOVE_OP, 8'h00, 1'b1, 1'b1, 8'h00, 8'h3C);
        chk(dataAddr, 12'h7AB);
        chk(resultData, 8'h3C);
        @(posedge sys_clk);
        progLit <= 20'hABCDE;
        ex(OP_JUMP, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
        chk({progJump, progTarget}, 21'h1ABCDE);
        $display("direct test done");
    endtask

    task automatic t_indirect;
        logic [7:0] fs[5] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h80};
        logic [11:0] as[5] = '{12'h1FF, 12'h200, 12'h200, 12'h1FE, 12'h200};
        regw(4'h2, 8'hFF);
        regw(4'h3, 8'hF1);
        regr(4'h3, rd);
        chk(rd, 8'h01);
        for (int i = 0; i < 5; i++) begin
            ex(OP_WORKING_TO_FILE_MOVE_OP, fs[i], 1'b0, 1'b1, 8'hFE, 8'h00);
            chk(dataAddr, as[i]);
        end
        regr(4'h2, rd);
        chk(rd, 8'h00);
        chk(flagsOut, 8'h11);
        regw(4'h1, 8'h0F);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h80, 1'b1, 1'b1, 8'h00, 8'h00);
        chk(dataAddr, 12'h200);
        regw(4'h4, 8'h45);
        regw(4'h5, 8'h03);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h88, 1'b0, 1'b1, 8'h00, 8'h00);
        chk(dataAddr, 12'h345);
        regw(4'h2, 8'h88);
        regw(4'h3, 8'h0F);
        ex(OP_WORKING_TO_FILE_MOVE_OP, 8'h80, 1'b0, 1'b1, 8'h77, 8'h00);
        chk(fileWrite, 0);
        ex(OP_ADD_WORKING_FILE_OP, 8'h80, 1'b0, 1'b0, 8'h05, 8'hAA);
        chk(resultData, 8'h05);
        ex(OP_ANDWF, 8'h80, 1'b0, 1'b0, 8'hFF, 8'hAA);
        chk({resultData, workWrite}, 9'h001);
        $display("indirect test done");
    endtask

    task automatic t_ext;
        logic [7:0] fs[4] = '{8'h10, 8'h5F, 8'h60, 8'h10};
        logic [11:0] as[4] = '{12'h310, 12'h35F, 12'hF60, 12'h010};
        regw(4'h6, 8'h00);
        regw(4'h7, 8'h03);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            extIsaEnable <= (i < 3);
            ex(OP_WORKING_TO_FILE_MOVE_OP, fs[i], 1'b0, 1'b1, 8'h00, 8'h00);
            chk(dataAddr, as[i]);
        end
        $display("extended mode test done");
    endtask

    // The watchdog only guards against a stalled simulator; every wait above is a fixed count.
    initial begin
        #2500000;
        errorCnt++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        t_reset;
        t_arith;
        t_rotate;
        t_flagdest;
        t_direct;
        t_indirect;
        t_ext;
        end_sim;
    end
endmodule // core_flags_addr_tb
